// ==== src/sbe_slip_event_status.v ====
// Notes on behaviour
// RQ1: Status bit 1 records receive buffer underflow since last read.
// RQ2: Receive read while empty replays a frame and sets underflow flag.
// RQ3: Receive write while full drops a frame and sets overflow flag.
// RQ4: Status bit 0 sets on any receive replay or drop.
// RQ5: Status flags reset to zero, clear on read, also clear by write.
// RQ6: Software checks underflow or overflow flag to classify a slip.
// RQ7: Enable bit 7 gates transmit overflow interrupt.
// RQ8: Enable bit 6 gates transmit underflow interrupt.
// RQ9: Enable bit 5 gates transmit slip interrupt.
// RQ10: Enables: zero disables, one enables, reset zero, read/write.
// RQ11: Transmit read while empty repeats a frame and sets status.
// RQ12: Transmit write while full deletes a frame and sets status.
// RQ13: Status bit 7 holds transmit overflow, cleared on read.
// RQ14: Status bits 5 and 6 hold transmit slip and underflow.
// RQ15: Enable bits 2, 1, 0 gate receive overflow, underflow, slip.
// RQ16: Interrupt asserts while any enabled flag is set.
`timescale 1ns/10ps
`default_nettype none
`include "sbe_map.vh"
module sbe_slip_event_status (
    // Clock and reset
    input wire ref_clk,
    input wire rst_n,
    // Slip buffer events, one-cycle strobes from the buffer datapath
    input wire rxReadEmpty,
    input wire rxWriteFull,
    input wire txReadEmpty,
    input wire txWriteFull,
    // AXI4-Lite write address
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // AXI4-Lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Interrupt request
    output reg slipIrq_q
);
    reg [7:0] enable_q;
    reg [3:0] awAddr_q;
    reg [31:0] wData_q;
    reg [3:0] wStrb_q;
    reg awHave_q;
    reg wHave_q;
    wire [7:0] flags;
    reg [7:0] setVec;
    reg [7:0] clrVec;
    wire wrFire;
    wire rdFire;

    // Word address match, low two byte bits ignored
    function addrIs;
        input [3:0] a;
        input [3:0] refAddr;
        begin
            addrIs = (a[3:2] == refAddr[3:2]);
        end
    endfunction

    // Write fires once both address and data are held
    assign wrFire = awHave_q && wHave_q && !s_axi_bvalid;
    assign rdFire = s_axi_arvalid && s_axi_arready;

    // Map buffer strobes onto event bits
    always @* begin
        setVec = 8'h00;
        setVec[`SBE_BIT_RX_UNDER] = rxReadEmpty; // [RQ1] [RQ2]
        setVec[`SBE_BIT_RX_OVER] = rxWriteFull; // [RQ3]
        setVec[`SBE_BIT_RX_SLIP] = rxReadEmpty | rxWriteFull; // [RQ4]
        setVec[`SBE_BIT_TX_UNDER] = txReadEmpty; // [RQ11] [RQ14]
        setVec[`SBE_BIT_TX_OVER] = txWriteFull; // [RQ12] [RQ13]
        setVec[`SBE_BIT_TX_SLIP] = txReadEmpty | txWriteFull; // [RQ14]
    end

    // Clear on status read, or write-one-to-clear on status write
    always @* begin
        clrVec = 8'h00;
        if (rdFire && addrIs(s_axi_araddr, `SBE_ADDR_STATUS)) begin
            clrVec = 8'hFF; // [RQ5]
        end
        if (wrFire && addrIs(awAddr_q, `SBE_ADDR_STATUS) && wStrb_q[0]) begin
            clrVec = clrVec | wData_q[7:0]; // [RQ5]
        end
    end

    sbe_event_flags u_flags (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .setIn(setVec),
        .clearIn(clrVec),
        .flags_q(flags)
    );

    // Write channel: take address and data in either order, answer after both
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            awHave_q <= 1'b0;
            wHave_q <= 1'b0;
            awAddr_q <= 4'h0;
            wData_q <= 32'h0000_0000;
            wStrb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SBE_RESP_OKAY;
            enable_q <= `SBE_RESET_VAL;
        end else begin
            s_axi_awready <= !awHave_q && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready <= !wHave_q && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                awHave_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHave_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wrFire) begin
                s_axi_bvalid <= 1'b1;
                awHave_q <= 1'b0;
                wHave_q <= 1'b0;
                if (addrIs(awAddr_q, `SBE_ADDR_ENABLE)) begin
                    // Reserved bits 4 and 3 are not stored
                    if (wStrb_q[0]) begin
                        enable_q <= wData_q[7:0] & `SBE_IMPL_MASK; // [RQ7] [RQ8] [RQ9] [RQ10] [RQ15]
                    end
                    s_axi_bresp <= `SBE_RESP_OKAY;
                end else if (addrIs(awAddr_q, `SBE_ADDR_STATUS)) begin
                    s_axi_bresp <= `SBE_RESP_OKAY;
                end else begin
                    s_axi_bresp <= `SBE_RESP_SLVERR;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read channel: one read at a time, data one cycle after acceptance
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `SBE_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (rdFire) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `SBE_RESP_OKAY;
                if (addrIs(s_axi_araddr, `SBE_ADDR_STATUS)) begin
                    // Returns the value before the read clears it
                    s_axi_rdata <= {24'h000000, flags}; // [RQ5]
                end else if (addrIs(s_axi_araddr, `SBE_ADDR_ENABLE)) begin
                    s_axi_rdata <= {24'h000000, enable_q}; // [RQ10]
                end else begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `SBE_RESP_SLVERR;
                end
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Interrupt follows flags one cycle later, registered for a clean output
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            slipIrq_q <= 1'b0;
        end else begin
            slipIrq_q <= |(flags & enable_q); // [RQ16] [RQ7] [RQ8] [RQ9] [RQ15]
        end
    end
endmodule
`default_nettype wire

// ==== src/sbe_map.vh ====
`ifndef SBE_MAP_VH
`define SBE_MAP_VH
// Register byte addresses on the AXI4-Lite bus
`define SBE_ADDR_STATUS 4'h0
`define SBE_ADDR_ENABLE 4'h4
`define SBE_ADDR_W 4
// Event bit positions, shared by status and enable
`define SBE_BIT_RX_SLIP 0
`define SBE_BIT_RX_UNDER 1
`define SBE_BIT_RX_OVER 2
`define SBE_BIT_TX_SLIP 5
`define SBE_BIT_TX_UNDER 6
`define SBE_BIT_TX_OVER 7
// Implemented bits (4 and 3 reserved, read as zero)
`define SBE_IMPL_MASK 8'hE7
`define SBE_RESET_VAL 8'h00
`define SBE_RESP_OKAY 2'h0
`define SBE_RESP_SLVERR 2'h2
`endif

// ==== src/sbe_event_flags.v ====
`timescale 1ns/10ps
`default_nettype none
`include "sbe_map.vh"
// Sticky event flags with clear on read or write-one-to-clear
module sbe_event_flags (
    // Clock and reset
    input wire ref_clk,
    input wire rst_n,
    // Events and clears
    input wire [7:0] setIn,
    input wire [7:0] clearIn,
    // State
    output reg [7:0] flags_q
);
    // Set wins over clear so a same-cycle event is never lost
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_q <= `SBE_RESET_VAL;
        end else begin
            flags_q <= ((flags_q & ~clearIn) | setIn) & `SBE_IMPL_MASK; // [RQ5]
        end
    end
endmodule
`default_nettype wire

// ==== test/sbe_slip_event_status_assertions.sv ====
`timescale 1ns/10ps
`default_nettype none
module sbe_slip_checker (
    // Clock, reset, events
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic rxReadEmpty,
    input wire logic txWriteFull,
    // Register bus
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // Single domain, so clock and reset are shared
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // A strobe read back at once must already show in the status
    // Word decode ignores the two byte bits, as the register map does
    rx_under_a: assert property (rxReadEmpty ##1 (s_axi_arvalid && s_axi_arready && s_axi_araddr[3:2] == 2'h0)
        |=> s_axi_rdata[1:0] == 2'h3) else $error("rx underflow not in status");
    // Underflow bit 6 may still stand from an earlier event, so only 7 and 5 are required
    tx_over_a: assert property (txWriteFull ##1 (s_axi_arvalid && s_axi_arready && s_axi_araddr[3:2] == 2'h0)
        |=> s_axi_rdata[7] && s_axi_rdata[5]) else $error("tx overflow not in status");
    spare_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0 && s_axi_rdata[4:3] == 2'h0)
        else $error("spare read bits set");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("no read answer");
    read_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer repeated");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answering");
    write_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer repeated");
    aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write taken while answering");
    // Main scenarios
    cover property (rxReadEmpty);
    cover property (txWriteFull);
    cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind sbe_slip_event_status sbe_slip_checker chk (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .rxReadEmpty(rxReadEmpty),
    .txWriteFull(txWriteFull),
    .s_axi_awready(s_axi_awready),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready)
);
`default_nettype wire

// ==== test/sbe_slip_event_status_bench.sv ====
`timescale 1ns/10ps
`default_nettype none
module sbe_slip_event_status_bench;
    // Ready lines stay high, so every answer is taken at once
    logic ref_clk = 1'h0, rst_n = 1'h0, rxReadEmpty = 1'h0, rxWriteFull = 1'h0, txReadEmpty = 1'h0;
    logic txWriteFull = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
    logic s_axi_bready = 1'h1, s_axi_rready = 1'h1, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, slipIrq_q;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    int error_cnt = 0, n_compared = 0;
    // Rows: strobes {txWriteFull, txReadEmpty, rxWriteFull, rxReadEmpty}, expected status
    logic [11:0] rows [4] = '{12'h103, 12'h205, 12'h460, 12'h8A0};
    sbe_slip_event_status dut (
        .ref_clk(ref_clk), .rst_n(rst_n),
        .rxReadEmpty(rxReadEmpty), .rxWriteFull(rxWriteFull),
        .txReadEmpty(txReadEmpty), .txWriteFull(txWriteFull),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .slipIrq_q(slipIrq_q)
    );
    // 40 MHz clock
    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end
    task chk(input [31:0] got, input [31:0] want);
        n_compared++;
        if (got !== want) begin
            error_cnt++;
            $display("MISMATCH t=%0t got %h want %h", $time, got, want);
        end
    endtask
    // Strobes for one cycle; never called twice back to back
    task pulse(input [3:0] e);
        {txWriteFull, txReadEmpty, rxWriteFull, rxReadEmpty} <= e;
        @(posedge ref_clk);
        {txWriteFull, txReadEmpty, rxWriteFull, rxReadEmpty} <= 4'h0;
    endtask
    // Address and data offered together, each dropped once taken
    task wr(input [3:0] a, input [31:0] d, input [1:0] r);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} <= {a, d, 2'h3};
        do begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        chk(s_axi_bresp, r);
    endtask
    task rd(input [3:0] a, input [7:0] d, input [1:0] r);
        {s_axi_araddr, s_axi_arvalid} <= {a, 1'h1};
        do begin
            @(posedge ref_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        chk(s_axi_rdata, {24'h0, d});
        chk(s_axi_rresp, r);
    endtask
    task print_verdict;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        // Reset held for two clock edges before release
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'h1;
        rd(4'h0, 8'h00, 2'h0);
        rd(4'h4, 8'h00, 2'h0);
        $display("test reset done");
        // Each event alone, read at once, then gone after the read
        for (int i = 0; i < 4; i++) begin
            pulse(rows[i][11:8]);
            rd(4'h0, rows[i][7:0], 2'h0);
            rd(4'h0, 8'h00, 2'h0);
            $display("test row %0d done", i);
        end
        // All events, then two flags cleared by a write
        pulse(4'hF);
        wr(4'h0, 32'h3, 2'h0);
        rd(4'h0, 8'hE4, 2'h0);
        // Rx enables only: tx underflow must stay silent
        wr(4'h4, 32'hFF1F, 2'h0);
        rd(4'h4, 8'h07, 2'h0);
        pulse(4'h4);
        repeat (2) @(posedge ref_clk);
        chk(slipIrq_q, 1'h0);
        wr(4'h4, 32'hE0, 2'h0);
        repeat (2) @(posedge ref_clk);
        chk(slipIrq_q, 1'h1);
        wr(4'h0, 32'hFF, 2'h0);
        repeat (2) @(posedge ref_clk);
        chk(slipIrq_q, 1'h0);
        // Unmapped place answers with an error and changes nothing
        wr(4'h8, 32'hFF, 2'h2);
        rd(4'h8, 8'h00, 2'h2);
        rd(4'h4, 8'hE0, 2'h0);
        $display("test irq and errors done");
        // Mid-run reset must drop flags, enables, interrupt and every ready and valid output
        pulse(4'hF);
        wr(4'h4, 32'hFF, 2'h0);
        rst_n <= 1'h0;
        repeat (2) @(posedge ref_clk);
        chk({s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid, slipIrq_q}, 32'h0);
        rst_n <= 1'h1;
        rd(4'h0, 8'h00, 2'h0);
        rd(4'h4, 8'h00, 2'h0);
        $display("test mid-run reset done");
        print_verdict;
    end
    // Run needs some 100 cycles
    initial begin
        #50us;
        error_cnt++;
        print_verdict;
    end
endmodule
`default_nettype wire
